// ---- logic/dus_pkg.sv ----
// Constants, types and register map of the door obstruction and usage statistics block
package dus_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ        = 64'd40_000_000;
  localparam longint unsigned WAIT_TIME_S   = 64'd2;
  localparam longint unsigned MINUTE_TIME_S = 64'd60;
  localparam longint unsigned WAIT_CYC_DEF  = WAIT_TIME_S * CLK_HZ;
  localparam longint unsigned MIN_CYC_DEF   = MINUTE_TIME_S * CLK_HZ;
  localparam logic [5:0]      MIN_PER_HOUR  = 6'h3C;

  // ----------------------------------------------------------------
  // Position, in millimetres, rising toward the open end
  // ----------------------------------------------------------------
  localparam int unsigned POS_W     = 16;
  localparam int unsigned MARGIN_CM = 2;
  localparam int unsigned MM_PER_CM = 10;
  localparam logic [POS_W:0] MARGIN_MM = (POS_W+1)'(MARGIN_CM * MM_PER_CM);

  // ----------------------------------------------------------------
  // Retained words
  // ----------------------------------------------------------------
  localparam int unsigned NV_WORDS = 7;
  localparam logic [2:0]  NV_OPEN  = 3'h0;
  localparam logic [2:0]  NV_BLOCK = 3'h1;
  localparam logic [2:0]  NV_LEARN = 3'h2;
  localparam logic [2:0]  NV_PWR   = 3'h3;
  localparam logic [2:0]  NV_HOURS = 3'h4;
  localparam logic [2:0]  NV_ELEC  = 3'h5;
  localparam logic [2:0]  NV_MECH  = 3'h6;
  localparam logic [2:0]  NV_LAST  = NV_MECH;

  // ----------------------------------------------------------------
  // Register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CMD    = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_STAT0  = 4'h3;
  localparam logic [3:0] REG_BLKPOS = 4'hA;

  localparam int unsigned CTRL_CM_BIT    = 0;
  localparam int unsigned CTRL_RETRY_LSB = 4;
  localparam int unsigned RETRY_W        = 4;
  localparam logic [RETRY_W-1:0] RETRY_DEFAULT = 4'h3;
  localparam int unsigned CMD_DEL_BIT    = 0;

  localparam int unsigned ST_RUN_BIT   = 0;
  localparam int unsigned ST_CBLK_BIT  = 1;
  localparam int unsigned ST_OBLK_BIT  = 2;
  localparam int unsigned ST_RETRY_LSB = 4;
  localparam int unsigned ST_STATE_LSB = 8;
  localparam int unsigned BLK_OPEN_LSB = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CLOSE, ST_REVERSE, ST_REOPEN, ST_OPEN, ST_OPEN_WAIT, ST_OPEN_HOLD
  } dus_state_t;

  typedef struct packed {
    logic             blocked;
    logic             moving;
    logic             at_open;
    logic             at_closed;
    logic [POS_W-1:0] pos;
  } dus_sense_t;

  typedef struct packed {
    logic en;
    logic open;
    logic slow;
  } dus_drive_t;

endpackage

// ---- logic/dus_nv_store.sv ----
// Retentive word store with registered read data
`timescale 1ns/100ps
module dus_nv_store #(
  parameter int unsigned AW    = 3,
  parameter int unsigned DW    = 32,
  parameter int unsigned DEPTH = 7
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  // Array has no reset: it keeps its contents over a restart; a blank part reads zero
  logic [DW-1:0] mem [DEPTH] = '{default: '0};

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= mem[rd_addr];
  end

endmodule // dus_nv_store

// ---- logic/dus_door_stats.sv ----
// Door obstruction handling and retained usage statistics
//
// Behaviour
// (R1) Closing blockage: halt, then drive open
// (R2) Re-close normal, slow 2 cm before blockage
// (R3) Repeat reverse cycle while blockage persists
// (R4) Slow until 2 cm past blockage, then normal
// (R5) Opening blockage: halt, wait 2 s, retry
// (R6) At most three opening retries, then stay
// (R7) New open command: slow near stored blockage
// (R8) Retry count settable; zero de-energises at once
// (R9) Maintenance message after each complete door cycle
// (R10) Delete clears usage counters, never operating hours or energy totals
// (R11) Count openings started from closed position
// (R12) Count blockages met while closing
// (R13) Count only successful learn runs
// (R14) Count restarts when parameter set valid
// (R15) Hours every 60 minutes; minutes restart
// (R16) Energy totals accumulate, saved hourly, restored
// (R17) Electrical total counts motor energy only
// (R18) Energised standstill: electrical rises, mechanical holds
// (R19) Energy reads return live accumulator values
// (R20) Capture blockage position, compare with margin
// (R21) Usage counters saturate instead of wrapping
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
module dus_door_stats
  import dus_pkg::*;
#(
  parameter longint unsigned WAIT_CYC = WAIT_CYC_DEF,
  parameter longint unsigned MIN_CYC  = MIN_CYC_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Controller door commands
  input  wire logic        cmd_open,
  input  wire logic        cmd_close,
  // Drive feedback
  input  wire dus_sense_t  sense,
  input  wire logic        learn_ok,
  input  wire logic        param_valid,
  input  wire logic [15:0] elec_sample,
  input  wire logic [15:0] mech_sample,
  // Motor control and maintenance message
  output dus_drive_t       drive,
  output logic             mpdo_send,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic within_margin(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    within_margin = {1'b0, a} <= ({1'b0, b} + MARGIN_MM);
  endfunction

  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[32] ? 32'hFFFF_FFFF : s[31:0];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dus_state_t         state;
  dus_state_t         next_state;
  logic               run;
  logic [3:0]         rs_cnt;
  logic               nv_rd_en;
  logic               ld_vld;
  logic [2:0]         ld_idx;
  logic [31:0]        nv_rd_data;
  logic [2:0]         wr_idx;
  logic               nv_wr_en;
  logic               save_pend;
  logic               save_act;
  logic [31:0]        cnt [NV_WORDS];
  logic [31:0]        add_val [NV_WORDS];
  logic               cm_en;
  logic [RETRY_W-1:0] cfg_retries;
  logic [RETRY_W-1:0] retry_left;
  logic [31:0]        wait_cnt;
  logic [31:0]        min_cyc;
  logic [5:0]         minute;
  logic               hour_tick;
  logic               stat_del;
  logic               pwr_inc;
  logic [POS_W-1:0]   blk_close_pos;
  logic [POS_W-1:0]   blk_open_pos;
  logic               blk_close_valid;
  logic               blk_open_valid;
  logic               opened_flag;
  logic               ev_cblk;
  logic               ev_oblk;
  logic               ev_ostart;
  logic               ev_oend;
  logic               ev_cend;
  logic               ev_retry;

  // ----------------------------------------------------------------
  // Restore after restart, then sweep writes to the store
  // ----------------------------------------------------------------
  assign nv_rd_en = rs_cnt < 4'(NV_WORDS);
  assign pwr_inc  = ld_vld && (ld_idx == NV_LAST) && param_valid; // R14
  assign nv_wr_en = run && ((wr_idx < NV_ELEC) || save_act); // R16

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rs_cnt <= '0;
      ld_vld <= 1'b0;
      ld_idx <= '0;
      run    <= 1'b0;
    end
    else
    begin
      if (nv_rd_en)
        rs_cnt <= rs_cnt + 4'h1;
      ld_vld <= nv_rd_en;
      ld_idx <= rs_cnt[2:0];
      run    <= run | (ld_vld && (ld_idx == NV_LAST)); // R16
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_idx    <= '0;
      save_pend <= 1'b0;
      save_act  <= 1'b0;
    end
    else
    begin
      if (run)
        wr_idx <= (wr_idx == NV_LAST) ? 3'h0 : wr_idx + 3'h1;
      // Energy words go out as a pair, so a request waits for the pair to start
      save_act  <= (save_pend && (wr_idx == NV_HOURS)) ||
                   (save_act && (wr_idx != NV_LAST)); // R16
      // A new hour wins over the handover of the previous request
      save_pend <= hour_tick | (save_pend & ~(wr_idx == NV_HOURS)); // R16
    end
  end

  dus_nv_store #(
    .AW    (3),
    .DW    (32),
    .DEPTH (NV_WORDS)
  ) u_store (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (nv_wr_en),
    .wr_addr (wr_idx),
    .wr_data (cnt[wr_idx]),
    .rd_en   (nv_rd_en),
    .rd_addr (rs_cnt[2:0]),
    .rd_data (nv_rd_data)
  );

  // ----------------------------------------------------------------
  // Door sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    ev_cblk    = 1'b0;
    ev_oblk    = 1'b0;
    ev_ostart  = 1'b0;
    ev_oend    = 1'b0;
    ev_cend    = 1'b0;
    ev_retry   = 1'b0;
    if (run)
    begin
      case (state)
        ST_IDLE:
          if (cmd_open && !sense.at_open)
          begin
            next_state = ST_OPEN;
            ev_ostart  = 1'b1;
          end
          else if (cmd_close && !cmd_open && !sense.at_closed)
            next_state = ST_CLOSE;
        ST_CLOSE:
          if (cmd_open)
          begin
            next_state = ST_OPEN;
            ev_ostart  = 1'b1;
          end
          else if (!cmd_close)
            next_state = ST_IDLE;
          else if (sense.at_closed)
          begin
            next_state = ST_IDLE;
            ev_cend    = 1'b1;
          end
          else if (sense.blocked)
          begin
            next_state = ST_REVERSE; // R1
            ev_cblk    = 1'b1;
          end
        ST_REVERSE:
          next_state = ST_REOPEN; // R1
        ST_REOPEN:
          if (sense.at_open)
          begin
            next_state = cmd_close ? ST_CLOSE : ST_IDLE; // R2 R3
            ev_oend    = 1'b1;
          end
          else if (!cmd_close)
            next_state = ST_IDLE;
        ST_OPEN:
          if (!cmd_open)
            next_state = ST_IDLE;
          else if (sense.at_open)
          begin
            next_state = ST_IDLE;
            ev_oend    = 1'b1;
          end
          else if (sense.blocked)
          begin
            next_state = (retry_left == '0) ? ST_OPEN_HOLD : ST_OPEN_WAIT; // R5 R6 R8
            ev_oblk    = 1'b1;
          end
        ST_OPEN_WAIT:
          if (!cmd_open)
            next_state = ST_IDLE;
          else if (wait_cnt == 32'h0)
          begin
            next_state = ST_OPEN; // R5
            ev_retry   = 1'b1;
          end
        ST_OPEN_HOLD:
          if (!cmd_open)
            next_state = ST_IDLE;
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      retry_left <= '0;
      wait_cnt   <= '0;
    end
    else
    begin
      if (ev_ostart)
        retry_left <= cfg_retries; // R7 R8
      else if (ev_retry)
        retry_left <= retry_left - 1'b1; // R6
      if (ev_oblk)
        wait_cnt <= 32'(WAIT_CYC - 64'd1); // R5
      else if ((state == ST_OPEN_WAIT) && (wait_cnt != 32'h0))
        wait_cnt <= wait_cnt - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Stored blockage positions
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      blk_close_pos   <= '0;
      blk_close_valid <= 1'b0;
      blk_open_pos    <= '0;
      blk_open_valid  <= 1'b0;
    end
    else
    begin
      if (ev_cblk)
      begin
        blk_close_pos   <= sense.pos; // R20
        blk_close_valid <= 1'b1;
      end
      else if (ev_cend || ((state == ST_CLOSE) && !within_margin(blk_close_pos, sense.pos)))
        blk_close_valid <= 1'b0; // R4
      if (ev_oblk)
      begin
        blk_open_pos   <= sense.pos; // R20
        blk_open_valid <= 1'b1;
      end
      else if (ev_oend || ((state == ST_OPEN) && !within_margin(sense.pos, blk_open_pos)))
        blk_open_valid <= 1'b0; // R7
    end
  end

  // ----------------------------------------------------------------
  // Motor drive and maintenance message
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      drive <= '0;
    else
    begin
      drive.en   <= (next_state == ST_CLOSE) || (next_state == ST_REOPEN) ||
                    (next_state == ST_OPEN); // R8
      drive.open <= (next_state == ST_REOPEN) || (next_state == ST_OPEN);
      drive.slow <= ((next_state == ST_CLOSE) && blk_close_valid &&
                     within_margin(sense.pos, blk_close_pos)) || // R2 R4
                    ((next_state == ST_OPEN) && blk_open_valid &&
                     within_margin(blk_open_pos, sense.pos)); // R7
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opened_flag <= 1'b0;
      mpdo_send   <= 1'b0;
    end
    else
    begin
      if (ev_oend)
        opened_flag <= 1'b1;
      else if (ev_cend)
        opened_flag <= 1'b0;
      mpdo_send <= ev_cend && opened_flag && cm_en; // R9
    end
  end

  // ----------------------------------------------------------------
  // Operating time
  // ----------------------------------------------------------------
  assign hour_tick = run && (min_cyc == 32'(MIN_CYC - 64'd1)) &&
                     (minute == MIN_PER_HOUR - 6'h1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      min_cyc <= '0; // R15
      minute  <= '0;
    end
    else if (run)
    begin
      if (min_cyc == 32'(MIN_CYC - 64'd1))
      begin
        min_cyc <= '0;
        minute  <= (minute == MIN_PER_HOUR - 6'h1) ? 6'h0 : minute + 6'h1;
      end
      else
        min_cyc <= min_cyc + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Usage counters and energy totals
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NV_WORDS; i++)
      add_val[i] = '0;
    add_val[NV_OPEN]  = 32'(ev_ostart & sense.at_closed); // R11
    add_val[NV_BLOCK] = 32'(ev_cblk); // R12
    add_val[NV_LEARN] = 32'(run & learn_ok); // R13
    add_val[NV_PWR]   = 32'(pwr_inc); // R14
    add_val[NV_HOURS] = 32'(hour_tick); // R15
    add_val[NV_ELEC]  = 32'(drive.en ? elec_sample : 16'h0); // R17 R18
    add_val[NV_MECH]  = 32'((drive.en && sense.moving) ? mech_sample : 16'h0); // R18
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NV_WORDS; i++)
        cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NV_WORDS; i++)
      begin
        if (ld_vld && (ld_idx == 3'(i)))
          cnt[i] <= nv_rd_data; // R16
        else if (stat_del && (i < int'(NV_HOURS)))
          cnt[i] <= add_val[i]; // R10
        else
          cnt[i] <= sat_add(cnt[i], add_val[i]); // R21
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  assign stat_del = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_DEL_BIT];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cm_en       <= 1'b0;
      cfg_retries <= RETRY_DEFAULT; // R8
    end
    else if (reg_wr && (reg_addr == REG_CTRL))
    begin
      cm_en       <= reg_wdata[CTRL_CM_BIT];
      cfg_retries <= reg_wdata[CTRL_RETRY_LSB +: RETRY_W];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        if (reg_addr == REG_CTRL)
        begin
          reg_rdata[CTRL_CM_BIT]                 <= cm_en;
          reg_rdata[CTRL_RETRY_LSB +: RETRY_W]   <= cfg_retries;
        end
        else if (reg_addr == REG_STATUS)
        begin
          reg_rdata[ST_RUN_BIT]                  <= run;
          reg_rdata[ST_CBLK_BIT]                 <= blk_close_valid;
          reg_rdata[ST_OBLK_BIT]                 <= blk_open_valid;
          reg_rdata[ST_RETRY_LSB +: RETRY_W]     <= retry_left;
          reg_rdata[ST_STATE_LSB +: 3]           <= state;
        end
        else if ((reg_addr >= REG_STAT0) && (reg_addr < REG_STAT0 + 4'(NV_WORDS)))
          reg_rdata <= cnt[3'(reg_addr - REG_STAT0)]; // R19
        else if (reg_addr == REG_BLKPOS)
        begin
          reg_rdata[POS_W-1:0]                   <= blk_close_pos;
          reg_rdata[BLK_OPEN_LSB +: POS_W]       <= blk_open_pos;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_close_block_rev: assert property (@(posedge clk) disable iff (rst) // R1
    (state == ST_CLOSE) && cmd_close && !cmd_open && !sense.at_closed && sense.blocked
    |=> (state == ST_REVERSE) && drive.en == 1'b0 ##1 (state == ST_REOPEN) && drive.open)
    else $error("closing blockage not reversed");

  chk_reclose_slow: assert property (@(posedge clk) disable iff (rst) // R2
    (next_state == ST_CLOSE) && blk_close_valid && within_margin(sense.pos, blk_close_pos)
    |=> drive.slow && drive.en && !drive.open)
    else $error("no slow speed near closing blockage");

  chk_open_retry_wait: assert property (@(posedge clk) disable iff (rst) // R5
    (state == ST_OPEN) && cmd_open && !sense.at_open && sense.blocked && (retry_left != '0)
    |=> (state == ST_OPEN_WAIT) && !drive.en && (wait_cnt == 32'(WAIT_CYC - 64'd1)))
    else $error("opening blockage did not start wait");

  chk_wait_expiry: assert property (@(posedge clk) disable iff (rst) // R5
    (state == ST_OPEN_WAIT) && cmd_open && (wait_cnt == 32'h0)
    |=> (state == ST_OPEN) && drive.en && (retry_left == $past(retry_left) - 1'b1))
    else $error("retry not taken after wait");

  chk_retry_exhaust: assert property (@(posedge clk) disable iff (rst) // R6
    (state == ST_OPEN) && cmd_open && !sense.at_open && sense.blocked && (retry_left == '0)
    |=> (state == ST_OPEN_HOLD) && !drive.en)
    else $error("door not held after last retry");

  chk_hold_off: assert property (@(posedge clk) disable iff (rst) // R8
    (state == ST_OPEN_HOLD) |-> !drive.en)
    else $error("motor energised while held");

  chk_mpdo_gate: assert property (@(posedge clk) disable iff (rst) // R9
    mpdo_send |-> $past(cm_en) && $past(opened_flag) && $past(state) == ST_CLOSE)
    else $error("maintenance message without completed cycle");

  chk_delete_hours: assert property (@(posedge clk) disable iff (rst) // R10
    stat_del && !ld_vld |=> (cnt[NV_OPEN] <= 32'h1) && (cnt[NV_HOURS] >= $past(cnt[NV_HOURS])))
    else $error("delete handled wrongly");

  chk_block_count: assert property (@(posedge clk) disable iff (rst) // R12
    ev_cblk && !stat_del && (cnt[NV_BLOCK] != 32'hFFFF_FFFF)
    |=> cnt[NV_BLOCK] == $past(cnt[NV_BLOCK]) + 32'h1)
    else $error("blockage not counted");

  chk_energy_stall: assert property (@(posedge clk) disable iff (rst) // R18
    run && drive.en && !sense.moving |=> $stable(cnt[NV_MECH]))
    else $error("mechanical total moved at standstill");

endmodule // dus_door_stats

// ---- tb/dus_door_model.sv ----
// Door leaf model driven by the block, with a settable obstacle
`timescale 1ns/100ps
module dus_door_model
  import dus_pkg::*;
#(
  parameter logic [15:0] OPEN_POS = 16'h00C8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Motor drive
  input  wire dus_drive_t  drive,
  // Obstacle
  input  wire logic [15:0] obst,
  input  wire logic        obst_on,
  input  wire logic        obst_up,
  // Feedback
  output dus_sense_t       sense
);
  logic [15:0] pos;
  logic        jam;
  logic        stop;

  // Obstacle only stops travel in its own direction
  assign jam  = obst_on && drive.en && pos == obst && drive.open == obst_up;
  assign stop = drive.open ? pos == OPEN_POS : pos == 16'h0000;
  assign sense = '{jam, drive.en && !jam && !stop, pos == OPEN_POS, pos == 16'h0000, pos};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pos <= 16'h0000;
    else if (drive.en && !jam && !stop)
      pos <= drive.open ? pos + 16'h0001 : pos - 16'h0001;
  end
endmodule // dus_door_model

// ---- tb/dus_door_stats_test.sv ----
// Self-checking bench for the door obstruction and statistics block
`timescale 1ns/100ps
module dus_door_stats_test
  import dus_pkg::*;
;
  logic        clk, rst, cmd_open, cmd_close, learn_ok, param_valid;
  logic        reg_wr, reg_rd, obst_on, obst_up, mpdo_send, p;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, e0, m0;
  logic [15:0] obst, tgt;
  dus_sense_t  sense;
  dus_drive_t  drive;
  int          err_count, n_compared, k;

  dus_door_stats #(.WAIT_CYC(20), .MIN_CYC(5)) uut (
    .clk(clk), .rst(rst), .cmd_open(cmd_open), .cmd_close(cmd_close),
    .sense(sense), .learn_ok(learn_ok), .param_valid(param_valid),
    .elec_sample(16'h0001), .mech_sample(16'h0001), .drive(drive),
    .mpdo_send(mpdo_send), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dus_door_model door (.clk(clk), .rst(rst), .drive(drive), .obst(obst),
    .obst_on(obst_on), .obst_up(obst_up), .sense(sense));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
    close_out();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  function automatic logic cond(input int c);
    case (c)
      0: return drive.en === 1'b0;
      1: return drive.en === 1'b1 && drive.open === 1'b1;
      2: return sense.at_open === 1'b1;
      3: return mpdo_send === 1'b1;
      4: return sense.pos === tgt;
      default: return sense.blocked === 1'b1;
    endcase
  endfunction

  task automatic wt(input int c, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1;
      if (cond(c))
        return;
    end
    fail("wait timed out");
  endtask

  task automatic falls(input int n);
    k = 0;
    p = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1;
      if (drive.en === 1'b0 && p === 1'b1)
        k++;
      p = drive.en;
    end
  endtask

  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      rd(REG_STATUS);
      if (v[ST_RUN_BIT] === 1'b1)
        return;
    end
    fail("no run");
  endtask

  task automatic move(input logic o, input logic c);
    @(posedge clk);
    cmd_open <= o;
    cmd_close <= c;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    do_reset(12);
    rd(REG_CTRL);
    chk(v[7:0], 32'h30);
    wr(REG_CMD, 32'h1);
    rd(REG_STAT0 + 4'h3);
    chk(v, 32'h0);
    @(posedge clk);
    learn_ok <= 1'b1;
    @(posedge clk);
    learn_ok <= 1'b0;
    rd(REG_STAT0 + 4'h2);
    chk(v, 32'h1);
    repeat (8) @(posedge clk);
    do_reset(2);
    rd(REG_STAT0 + 4'h3);
    chk(v, 32'h1);
    param_valid <= 1'b0;
    repeat (8) @(posedge clk);
    do_reset(2);
    rd(REG_STAT0 + 4'h3);
    chk(v, 32'h1);
    rd(REG_STAT0 + 4'h2);
    chk(v, 32'h1);
    $display("boot test done");
  endtask

  task automatic t_cycle();
    wr(REG_CTRL, 32'h31);
    rd(REG_STAT0 + 4'h5);
    e0 = v;
    rd(REG_STAT0 + 4'h6);
    m0 = v;
    move(1'b1, 1'b0);
    wt(2, 400);
    rd(REG_STAT0);
    chk(v, 32'h1);
    rd(REG_STAT0 + 4'h5);
    chk(v - e0, 32'hC9);
    rd(REG_STAT0 + 4'h6);
    chk(v - m0, 32'hC8);
    move(1'b0, 1'b1);
    wt(3, 400);
    $display("cycle test done");
  endtask

  task automatic t_close_blk();
    move(1'b1, 1'b0);
    wt(2, 400);
    obst <= 16'h0064;
    obst_on <= 1'b1;
    move(1'b0, 1'b1);
    wt(5, 400);
    wt(0, 3);
    wt(1, 3);
    rd(REG_BLKPOS);
    chk(v[15:0], 32'h64);
    rd(REG_STAT0 + 4'h1);
    chk(v, 32'h1);
    wt(2, 400);
    tgt = 16'h0096;
    wt(4, 400);
    chk(drive.slow, 1'b0);
    tgt = 16'h006E;
    wt(4, 400);
    chk(drive.slow, 1'b1);
    wt(5, 400);
    rd(REG_STAT0 + 4'h1);
    chk(v, 32'h2);
    obst_on <= 1'b0;
    wt(2, 400);
    tgt = 16'h005A;
    wt(4, 400);
    chk(drive.slow, 1'b1);
    tgt = 16'h0046;
    wt(4, 400);
    chk(drive.slow, 1'b0);
    tgt = 16'h0000;
    wt(4, 400);
    $display("close blockage test done");
  endtask

  task automatic t_open_blk();
    obst <= 16'h0032;
    obst_up <= 1'b1;
    obst_on <= 1'b1;
    move(1'b1, 1'b0);
    falls(400);
    chk(k, 4);
    rd(REG_STATUS);
    chk(v[10:8], 32'h6);
    obst_on <= 1'b0;
    move(1'b0, 1'b1);
    wt(4, 400);
    wr(REG_CTRL, 32'h01);
    obst_on <= 1'b1;
    move(1'b1, 1'b0);
    tgt = 16'h0014;
    wt(4, 100);
    chk(drive.slow, 1'b0);
    tgt = 16'h0028;
    wt(4, 100);
    chk(drive.slow, 1'b1);
    falls(100);
    chk(k, 1);
    $display("open blockage test done");
  endtask

  initial
  begin
    rst = 1'b1;
    cmd_open = 1'b0;
    cmd_close = 1'b0;
    learn_ok = 1'b0;
    param_valid = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    obst = 16'h0000;
    obst_on = 1'b0;
    obst_up = 1'b0;
    tgt = 16'h0000;
    t_boot();
    t_cycle();
    t_close_blk();
    t_open_blk();
    close_out();
  end
endmodule // dus_door_stats_test
